/* include/roll_timing_cfg.svh */
// Functional notes
// R1 - Comparators work only in roll mode
// R2 - Compare output high only on full equality
// R3 - Ramp start needs low and top matches
// R4 - Ramp start match strobed by phase four
// R5 - Phase five after trigger latches write address
// R6 - Stop compare: low bits, top plus offset
// R7 - Offset zero stops during first phase
// R8 - Offsets 1..3 delay stop by quarters
// R9 - Offset forced zero during trigger enable
// R10 - Bright-up: read equals latch, two gates high
// R11 - Mark trigger only in roll and stored
// R12 - Phase window high phase one to four
// R13 - Falling-edge toggles give half and quarter
// R14 - One-hot low selects pick prescale output
// R15 - Decade select lines set ratio 1..100000
// R16 - Divider pulse reclocked to one phase two
// R17 - Reclocked pulse steps write counter
// R18 - Top-bit offset sum wraps modulo four
// R19 - Five rotating phases, 110 ns each; code rounds each up to 5 clocks, 125 ns
// R20 - Stop output ends data entry
`ifndef ROLL_TIMING_CFG_SVH
`define ROLL_TIMING_CFG_SVH
`define CLK_PERIOD_NS 25
`define PHASE_WIDTH_NS 110
`define PHASE_CYCLES ((`PHASE_WIDTH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ADDR_W 10
`define LOW_W 8
`define PHASE_RST 5'h01
`define DEC_RATIO_1 17'h00001
`define DEC_RATIO_10 17'h0000A
`define DEC_RATIO_100 17'h00064
`define DEC_RATIO_1000 17'h003E8
`define DEC_RATIO_10000 17'h02710
`define DEC_RATIO_100000 17'h186A0
`endif

/* include/roll_timing_pkg.sv */
package roll_timing_pkg;
    typedef logic [9:0] addr_t;
    typedef logic [2:0] ph_cnt_t;
endpackage

/* src/roll_compare_range_divider.sv */
`timescale 1ns/1ps
`include "roll_timing_cfg.svh"
module roll_compare_range_divider (
    input wire logic clk,
    input wire logic sys_rst,
    input wire roll_timing_pkg::addr_t read_addr,
    input wire roll_timing_pkg::addr_t write_addr,
    input wire logic roll_mode,
    input wire logic trigger,
    input wire logic store_lit,
    input wire logic [1:0] trigger_offset_select,
    input wire logic offset_zero_gate,
    input wire logic bright_gate_a,
    input wire logic bright_gate_b,
    input wire logic prescale_sel_full_n,
    input wire logic prescale_sel_half_n,
    input wire logic prescale_sel_quarter_n,
    input wire logic decade_sel_a,
    input wire logic decade_sel_b,
    input wire logic decade_sel_c,
    input wire logic write_step_gate,
    output logic phase_one,
    output logic phase_two,
    output logic phase_three,
    output logic phase_four,
    output logic phase_five,
    output logic phase_window,
    output logic phase_window_n,
    output logic ramp_start,
    output logic stop_on_roll,
    output logic enter_data_stop,
    output logic bright_up,
    output roll_timing_pkg::addr_t trigger_point,
    output logic write_step
);
    import roll_timing_pkg::*;

    // All five phases come from one counter, so phase edges fall on clk
    // edges; phase widths round up to whole clock periods, which makes
    // the phase period a little longer than the nominal figure.

    // Equality of two fields; one function serves the low-byte compare of all three comparators
    function automatic logic eq10(input addr_t a, input addr_t b);
        eq10 = (a == b);
    endfunction

    // Ratio of the decade stage; the other three codes divide by one
    function automatic logic [16:0] decade_ratio(input logic [2:0] sel);
        unique case (sel) // [R15]
            3'h4: decade_ratio = `DEC_RATIO_10;
            3'h2: decade_ratio = `DEC_RATIO_100;
            3'h6: decade_ratio = `DEC_RATIO_1000;
            3'h1: decade_ratio = `DEC_RATIO_10000;
            3'h5: decade_ratio = `DEC_RATIO_100000;
            default: decade_ratio = `DEC_RATIO_1;
        endcase
    endfunction

    // Edge tests against a registered copy of the same signal
    function automatic logic fell(input logic prev, input logic now);
        fell = prev & ~now;
    endfunction

    function automatic logic rose(input logic prev, input logic now);
        rose = ~prev & now;
    endfunction

    // Phase ring: one-hot phase, sub-count within a phase, window
    logic [4:0] phase_q, phase_d;
    ph_cnt_t sub_q, sub_d;
    logic win_q, win_d;

    // Prescaler: edge history and the two toggle stages
    logic half_q, half_d, quarter_q, quarter_d;
    logic win_prev_q, win_prev_d, half_prev_q, half_prev_d;
    logic pre_prev_q, pre_prev_d;
    logic pre_out;

    // Decade divider
    logic [16:0] dec_q, dec_d;
    logic [16:0] dec_ratio;
    logic dec_pulse;

    // Reclocking pair that shapes the write step
    logic rc1_q, rc1_d, rc2_q, rc2_d;

    // Trigger synchroniser, arming flag and trigger point latch
    logic trig_s1_q, trig_s2_q;
    logic trig_pend_q, trig_pend_d;
    addr_t tp_q, tp_d;

    // Comparator terms and their registered results
    logic [1:0] off_eff, top_sum;
    logic low_rw, top_rw, low_tw, top_tw, low_tr, top_tr;
    logic ramp_q, ramp_d, stop_q, stop_d, bright_q, bright_d;

    // Trigger comes from the analogue side: two-stage synchroniser
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            trig_s1_q <= 1'b0;
            trig_s2_q <= 1'b0;
        end else begin
            trig_s1_q <= trigger;
            trig_s2_q <= trig_s1_q;
        end
    end

    // Five phase ring, each phase held PHASE_CYCLES clocks
    always_comb begin
        sub_d = sub_q + 3'h1;
        phase_d = phase_q;
        if (sub_q == ph_cnt_t'(`PHASE_CYCLES - 1)) begin
            sub_d = 3'h0;
            phase_d = {phase_q[3:0], phase_q[4]}; // [R19]
        end
        // Window set by phase one, cleared by phase four
        win_d = win_q;
        if (phase_q[0]) win_d = 1'b1; // [R12]
        if (phase_q[3]) win_d = 1'b0; // [R12]
    end

    // Falling-edge toggles: window halves, then halves again
    always_comb begin
        win_prev_d = win_q;
        half_prev_d = half_q;
        half_d = half_q;
        quarter_d = quarter_q;
        // Both stages toggle on falling edges, like the stages they stand
        // in for; the quarter stage therefore ripples off the half stage
        if (fell(win_prev_q, win_q)) half_d = ~half_q; // [R13]
        if (fell(half_prev_q, half_q)) quarter_d = ~quarter_q; // [R13]
        // Active-low one-hot select of the prescaler tap
        pre_out = (!prescale_sel_full_n & ~win_q) |
                  (!prescale_sel_half_n & half_q) |
                  (!prescale_sel_quarter_n & quarter_q); // [R14]
        pre_prev_d = pre_out;
    end

    // Decade divider counts rising edges of the selected tap
    always_comb begin
        dec_ratio = decade_ratio({decade_sel_a, decade_sel_b, decade_sel_c});
        dec_d = dec_q;
        dec_pulse = 1'b0;
        if (rose(pre_prev_q, pre_out)) begin
            if (dec_q >= dec_ratio - 17'h00001) begin
                dec_d = 17'h00000;
                dec_pulse = 1'b1; // [R15]
            end else begin
                dec_d = dec_q + 17'h00001;
            end
        end
    end

    // Reclock: divider sets first flop, gated phase two sets second
    always_comb begin
        rc1_d = rc1_q;
        rc2_d = rc2_q;
        if (dec_pulse) rc1_d = 1'b1; // [R16]
        if (rc1_q && phase_q[1] && write_step_gate) begin
            rc2_d = 1'b1; // [R16]
            rc1_d = 1'b0;
        end
        // Phase three ends the pulse, so it runs one clock into phase three before it drops
        if (phase_q[2]) rc2_d = 1'b0; // [R16]
    end

    // Trigger latch loaded on the phase five after trigger
    always_comb begin
        trig_pend_d = trig_pend_q;
        tp_d = tp_q;
        // Arming needs roll mode; a trigger outside roll is dropped
        if (trig_s2_q && roll_mode) trig_pend_d = 1'b1;
        if (trig_pend_q && phase_q[4]) begin
            tp_d = write_addr; // [R5]
            trig_pend_d = 1'b0;
        end
    end

    // Ramp start: read against write, low byte and top bits both
    always_comb begin
        low_rw = eq10({2'h0, read_addr[7:0]},
                      {2'h0, write_addr[7:0]}); // [R2]
        top_rw = (read_addr[9:8] == write_addr[9:8]); // [R3]
        // Phase four strobes the result once the counters have settled
        ramp_d = roll_mode & low_rw & top_rw & phase_q[3]; // [R1] [R3] [R4]
    end

    // Stop on roll: latch low bits, and latch top bits plus the offset
    always_comb begin
        off_eff = offset_zero_gate ? 2'h0 : trigger_offset_select; // [R9]
        // Two-bit sum; a carry past the top of the store is dropped
        top_sum = 2'(tp_q[9:8] + off_eff); // [R18]
        low_tw = eq10({2'h0, tp_q[7:0]},
                      {2'h0, write_addr[7:0]}); // [R6]
        top_tw = (top_sum == write_addr[9:8]); // [R6]
        // Offset 0 matches at once; 1..3 wait quarters of count
        stop_d = roll_mode & store_lit & low_tw & top_tw
                 & phase_q[0]; // [R7] [R8]
    end

    // Bright-up: read against the latched trigger point, all ten bits
    always_comb begin
        low_tr = eq10({2'h0, read_addr[7:0]},
                      {2'h0, tp_q[7:0]}); // [R10]
        top_tr = (tp_q[9:8] == read_addr[9:8]); // [R10]
        // Mark only in roll mode with the stored indication lit
        bright_d = roll_mode & store_lit & low_tr & top_tr
                   & bright_gate_a & bright_gate_b; // [R10] [R11]
    end

    // Phase ring and window; reset parks the ring on phase one
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            phase_q <= `PHASE_RST;
            sub_q <= 3'h0;
            win_q <= 1'h0;
        end else begin
            phase_q <= phase_d;
            sub_q <= sub_d;
            win_q <= win_d;
        end
    end

    // Prescaler toggles and their edge history
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            win_prev_q <= 1'h0;
            half_q <= 1'h0;
            half_prev_q <= 1'h0;
            quarter_q <= 1'h0;
            pre_prev_q <= 1'h0;
        end else begin
            win_prev_q <= win_prev_d;
            half_q <= half_d;
            half_prev_q <= half_prev_d;
            quarter_q <= quarter_d;
            pre_prev_q <= pre_prev_d;
        end
    end

    // Decade count; a ratio change takes effect at the next tap edge, as the compare uses the live ratio
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dec_q <= 17'h00000;
        end else begin
            dec_q <= dec_d;
        end
    end

    // Reclocking pair
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rc1_q <= 1'h0;
            rc2_q <= 1'h0;
        end else begin
            rc1_q <= rc1_d;
            rc2_q <= rc2_d;
        end
    end

    // Trigger arming and trigger point latch
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            trig_pend_q <= 1'h0;
            tp_q <= 10'h000;
        end else begin
            trig_pend_q <= trig_pend_d;
            tp_q <= tp_d;
        end
    end

    // Comparator outputs, registered so they leave the block glitch free
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ramp_q <= 1'h0;
            stop_q <= 1'h0;
            bright_q <= 1'h0;
        end else begin
            ramp_q <= ramp_d;
            stop_q <= stop_d;
            bright_q <= bright_d;
        end
    end

    // Phase pulses straight from the ring
    assign phase_one = phase_q[0];
    assign phase_two = phase_q[1];
    assign phase_three = phase_q[2];
    assign phase_four = phase_q[3];
    assign phase_five = phase_q[4];

    // Window and its complement
    assign phase_window = win_q;
    assign phase_window_n = ~win_q; // [R12]

    // Comparator results; store control stops entry on the stop output
    assign ramp_start = ramp_q;
    assign stop_on_roll = stop_q;
    assign enter_data_stop = stop_q; // [R20]
    assign bright_up = bright_q;

    // Latch contents and the reclocked write step
    assign trigger_point = tp_q;
    assign write_step = rc2_q; // [R17]
endmodule // roll_compare_range_divider

/* tb/addr_counters.sv */
`timescale 1ns/1ps
module addr_counters (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic write_step,
    output roll_timing_pkg::addr_t read_addr,
    output roll_timing_pkg::addr_t write_addr
);
    import roll_timing_pkg::*;
    logic step_q;
    // Read side runs every clock so it sweeps past the write side often
    always_ff @(posedge clk) begin
        step_q <= write_step;
        read_addr <= sys_rst ? 10'h000 : read_addr + 10'h001;
        if (sys_rst)
            write_addr <= 10'h000;
        else if (write_step && !step_q)
            write_addr <= write_addr + 10'h001;
    end
endmodule // addr_counters

/* tb/roll_timing_chk.sv */
`timescale 1ns/1ps
module roll_timing_chk (
    input wire logic clk,
    input wire logic sys_rst,
    input wire roll_timing_pkg::addr_t read_addr,
    input wire roll_timing_pkg::addr_t write_addr,
    input wire roll_timing_pkg::addr_t trigger_point,
    input wire logic roll_mode,
    input wire logic store_lit,
    input wire logic [1:0] trigger_offset_select,
    input wire logic offset_zero_gate,
    input wire logic phase_one,
    input wire logic phase_two,
    input wire logic phase_four,
    input wire logic phase_window,
    input wire logic ramp_start,
    input wire logic stop_on_roll,
    input wire logic enter_data_stop,
    input wire logic write_step
);
    import roll_timing_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Phase one holds five clocks, then hands over to phase two
    sequence s_p1;
        phase_one [*5] ##1 phase_two;
    endsequence
    property p_ph; $rose(phase_one) |-> s_p1; endproperty
    a_ph: assert property (p_ph) else $error("phase width");
    property p_won; $rose(phase_one) |=> phase_window; endproperty
    a_won: assert property (p_won) else $error("window on");
    property p_woff; phase_four |=> !phase_window; endproperty
    a_woff: assert property (p_woff) else $error("window off");
    property p_ramp;
        roll_mode && read_addr == write_addr && phase_four |=> ramp_start;
    endproperty
    a_ramp: assert property (p_ramp) else $error("no ramp");
    property p_neq; read_addr[9:8] != write_addr[9:8] |=> !ramp_start;
    endproperty
    a_neq: assert property (p_neq) else $error("false ramp");
    property p_off; !roll_mode |=> !ramp_start && !stop_on_roll; endproperty
    a_off: assert property (p_off) else $error("out of roll");
    property p_step; $rose(write_step) |-> phase_two ##0 write_step [*3];
    endproperty
    a_step: assert property (p_step) else $error("step pulse");
    // Top bits are summed in two bits, so the carry falls away
    property p_stop;
        phase_one && roll_mode && store_lit
        && trigger_point[7:0] == write_addr[7:0]
        && 2'(trigger_point[9:8] + (offset_zero_gate ? 2'h0
        : trigger_offset_select)) == write_addr[9:8]
        |=> stop_on_roll && enter_data_stop;
    endproperty
    a_stop: assert property (p_stop) else $error("no stop");
endmodule // roll_timing_chk

bind roll_compare_range_divider roll_timing_chk roll_timing_chk_inst (.*);

/* tb/tb_roll_compare_range_divider.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb_roll_compare_range_divider;
    import roll_timing_pkg::*;
    logic clk = 1'h0, sys_rst = 1'h1, roll_mode = 1'h0, trigger = 1'h0;
    logic store_lit = 1'h0, offset_zero_gate = 1'h0, write_step_gate = 1'h1;
    logic bright_gate_a = 1'h0, bright_gate_b = 1'h0;
    logic [1:0] trigger_offset_select = 2'h0;
    logic [5:0] range_sel = 6'h18;
    logic prescale_sel_full_n, prescale_sel_half_n, prescale_sel_quarter_n;
    logic decade_sel_a, decade_sel_b, decade_sel_c, phase_one, phase_two;
    logic phase_three, phase_four, phase_five, phase_window, phase_window_n;
    logic ramp_start, stop_on_roll, enter_data_stop, bright_up, write_step;
    addr_t read_addr, write_addr, trigger_point;
    int num_errors = 0, n_compared = 0;
    assign {prescale_sel_full_n, prescale_sel_half_n, prescale_sel_quarter_n,
        decade_sel_a, decade_sel_b, decade_sel_c} = range_sel;
    always #12.5 clk = ~clk;
    roll_compare_range_divider roll_compare_range_divider_inst (.*);
    addr_counters addr_counters_inst (.*);
    task tick(input int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task print_verdict;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wait_hi(ref logic s, input int lim);
        int i;
        for (i = 0; i < lim && s !== 1'h1; i++)
            tick();
        if (i == lim) begin
            num_errors++;
            print_verdict();
        end
    endtask
    // Cycles from one step rise to the next; first call may be partial
    task automatic gap(output int n);
        bit lo = 0;
        n = 0;
        while (!(lo && write_step === 1'h1) && n < 3000) begin
            lo = lo || write_step === 1'h0;
            tick();
            n++;
        end
        if (n == 3000) begin
            num_errors++;
            print_verdict();
        end
    endtask
    task t_rate;
        logic [5:0] sel [5] = '{6'h18, 6'h28, 6'h30, 6'h1C, 6'h1A};
        int per [5] = '{25, 50, 100, 250, 2500};
        int n;
        for (int k = 0; k < 5; k++) begin
            range_sel = sel[k];
            repeat (3) gap(n);
            `CHK(n, per[k])
        end
        range_sel = 6'h18;
    endtask
    // Offset 3 with the zero gate high must stop like offset 0
    task t_stop;
        roll_mode = 1'h1;
        store_lit = 1'h1;
        for (int i = 0; i < 5; i++) begin
            trigger_offset_select = (i == 4) ? 2'h3 : i[1:0];
            offset_zero_gate = (i == 4);
            for (int j = 0; j < 10 && stop_on_roll; j++)
                tick();
            trigger = 1'h1;
            tick(2);
            trigger = 1'h0;
            wait_hi(stop_on_roll, 25000);
            `CHK(write_addr - trigger_point, 10'((i % 4) * 256))
            `CHK(enter_data_stop, 1'h1)
            `CHK(phase_one, 1'h1)
        end
    endtask
    task automatic quiet(output int c);
        c = 0;
        repeat (1100) begin
            tick();
            c += (bright_up !== 1'h0) || (!roll_mode && ramp_start !== 1'h0);
        end
    endtask
    task t_marks;
        int c;
        bright_gate_a = 1'h1;
        bright_gate_b = 1'h1;
        wait_hi(bright_up, 1100);
        `CHK(bright_up, 1'h1)
        wait_hi(ramp_start, 30000);
        `CHK(ramp_start, 1'h1)
        bright_gate_b = 1'h0;
        quiet(c);
        `CHK(c, 0)
        bright_gate_b = 1'h1;
        store_lit = 1'h0;
        quiet(c);
        `CHK(c, 0)
        roll_mode = 1'h0;
        quiet(c);
        `CHK(c, 0)
    endtask
    initial begin
        tick(8);
        `CHK(phase_one, 1'h1)
        `CHK(phase_window_n, 1'h1)
        `CHK(phase_window, 1'h0)
        sys_rst = 1'h0;
        t_rate();
        t_stop();
        t_marks();
        print_verdict();
    end
endmodule // tb_roll_compare_range_divider
